// file: logic/fsr_pkg.sv
// Package with opcodes, timing counts and register map of the suspend/latch block.
package fsr_pkg;
  localparam logic [7:0] OP_RESUME = 8'hD0;
  localparam logic [7:0] OP_SUSPEND = 8'hB0;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_PROG_ALT = 8'hA2;
  localparam logic [7:0] OP_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_ERASE_32K = 8'h52;
  localparam logic [7:0] OP_ERASE_64K = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_ALT = 8'hC7;
  localparam logic [7:0] OP_PROTECT = 8'h36;
  localparam logic [7:0] OP_UNPROTECT = 8'h39;
  localparam logic [7:0] OP_LOCKDOWN = 8'h33;
  localparam logic [7:0] OP_FREEZE = 8'h34;
  localparam logic [7:0] OP_OTP_PROG = 8'h9B;
  localparam logic [7:0] OP_WRSR1 = 8'h01;
  localparam logic [7:0] OP_WRSR2 = 8'h31;
  localparam logic [7:0] OP_DEEP_PD = 8'hB9;
  localparam logic [7:0] OP_DEEP_PD_EXIT = 8'hAB;
  localparam logic [7:0] OP_READ_A = 8'h03;
  localparam logic [7:0] OP_READ_B = 8'h0B;
  localparam logic [7:0] OP_READ_C = 8'h1B;
  localparam logic [7:0] OP_READ_D = 8'h3B;
  localparam logic [7:0] OP_RD_PROT = 8'h3C;
  localparam logic [7:0] OP_RD_LOCK = 8'h35;
  localparam logic [7:0] OP_RD_OTP = 8'h77;
  localparam logic [7:0] OP_RD_STATUS = 8'h05;
  localparam logic [7:0] OP_RESET = 8'hF0;
  localparam logic [7:0] OP_RD_ID = 8'h9F;
  // Resume latency in ns and its cycle count at the 200 MHz core clock.
  localparam int RESUME_LATENCY_NS = 60000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int RESUME_CYCLES = RESUME_LATENCY_NS / CLK_PERIOD_NS;
  localparam int SCK_HALF_CYCLES = 4;
  // Controller register byte offsets.
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  // Device state word bit positions as seen by the controller.
  localparam int ST_LATCH = 0;
  localparam int ST_PROG_SUSP = 1;
  localparam int ST_ERASE_SUSP = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_RESUMING = 4;
  localparam int ST_REFUSED = 5;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// file: logic/fsr_link_if.sv
// Interface joining the SPI controller and the flash command logic.
interface fsr_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic [7:0] dev_state;
  modport host (output cs_n, output sck, output mosi, input dev_state);
  modport dev (input cs_n, input sck, input mosi, output dev_state);
endinterface

// file: logic/fsr_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
module fsr_sync #(
  parameter int WIDTH = 3
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin,
  input wire logic [WIDTH-1:0] init,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_level;

  // Each bit keeps its level until the two later stages agree.
  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
        next_level[i] = (s2[i] == s3[i]) ? s3[i] : level[i];
      end
    end
  endgenerate

  // Stages and filtered level; reset values come from a constant port.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1 <= init;
      s2 <= init;
      s3 <= init;
      level <= init;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
    end
  end
endmodule

// file: logic/fsr_flash_cmd.sv
// Flash command logic: suspend, resume, command filter and write enable latch.
// How it works
// R1: Resume D0h restarts after the latency.
// R2: Resume clears the matching suspend flag.
// R3: Resume ignores the write enable latch.
// R4: Act only on whole-byte frames.
// R5: Program resumes before erase.
// R6: Suspend ignored while a resume is pending.
// R7: Host waits or polls before suspending again.
// R8: Program suspend allows reads, resume, reset, ID.
// R9: Erase suspend also allows program, suspend, latch.
// R10: Erase, protect, lockdown, OTP, status writes refused.
// R11: Opcode 06h sets the latch.
// R12: Opcode 04h clears the latch.
// R13: Broken latch frames leave the latch alone.
// R14: Writing commands need the latch set.
// R15: Suspend B0h halts work, sets flag, ready.
// R16: Refused commands change nothing.
// R17: Decode after eight clocks, act at deselect.
module fsr_flash_cmd
  import fsr_pkg::*;
#(
  parameter int RESUME_WAIT = RESUME_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  fsr_link_if.dev link,
  input wire logic op_start_prog,
  input wire logic op_start_erase,
  input wire logic op_done,
  output logic write_enable_latch,
  output logic program_suspended_flag,
  output logic erase_suspended_flag,
  output logic ready_busy_flag,
  output logic prog_active,
  output logic erase_active,
  output logic cmd_exec,
  output logic [7:0] cmd_opcode
);
  logic [2:0] pins;
  logic cs_q;
  logic sck_q;
  logic mosi_q;
  logic cs_d;
  logic sck_d;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [3:0] nbits;
  logic [3:0] next_nbits;
  logic [7:0] opcode;
  logic [7:0] next_opcode;
  logic have_op;
  logic next_have_op;
  logic aligned;
  logic next_aligned;
  logic next_latch;
  logic next_psusp;
  logic next_esusp;
  logic next_ready;
  logic next_pa;
  logic next_ea;
  logic next_exec;
  logic [7:0] next_cmd;
  logic refused;
  logic next_refused;
  logic [31:0] res_cnt;
  logic [31:0] next_res_cnt;
  logic allowed;
  logic needs_latch;
  logic cs_rise;

  fsr_sync #(.WIDTH(3)) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin({link.cs_n, link.sck, link.mosi}),
    .init(3'h4),
    .level(pins)
  );
  assign cs_q = pins[2];
  assign sck_q = pins[1];
  assign mosi_q = pins[0];
  assign cs_rise = cs_q && !cs_d;
  assign link.dev_state = {2'h0, refused, res_cnt != 32'h0, ready_busy_flag,
                           erase_suspended_flag, program_suspended_flag, write_enable_latch};

  // Suspend filter: program suspend set, plus extras when only erase is suspended.
  always_comb begin
    unique case (opcode)
      OP_READ_A, OP_READ_B, OP_READ_C, OP_READ_D, OP_RESUME, OP_RD_PROT,
      OP_RD_LOCK, OP_RD_OTP, OP_RD_STATUS, OP_RESET, OP_RD_ID: allowed = 1'b1; // R8
      OP_PROG, OP_PROG_ALT, OP_SUSPEND, OP_WREN, OP_WRDI:
        allowed = !program_suspended_flag; // R9
      default: allowed = 1'b0; // R10
    endcase
    if (!program_suspended_flag && !erase_suspended_flag) begin
      allowed = 1'b1;
    end
  end

  // Commands that require the latch before they run.
  always_comb begin
    unique case (opcode)
      OP_PROG, OP_PROG_ALT, OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K, OP_CHIP_ERASE,
      OP_CHIP_ERASE_ALT, OP_PROTECT, OP_UNPROTECT, OP_LOCKDOWN, OP_FREEZE,
      OP_OTP_PROG, OP_WRSR1, OP_WRSR2: needs_latch = 1'b1;
      default: needs_latch = 1'b0;
    endcase
  end

  // Byte capture on sampled SCK rising edges, then action on CS rise.
  always_comb begin
    next_shift = shift;
    next_nbits = nbits;
    next_opcode = opcode;
    next_have_op = have_op;
    next_aligned = aligned;
    next_latch = write_enable_latch;
    next_psusp = program_suspended_flag;
    next_esusp = erase_suspended_flag;
    next_pa = prog_active;
    next_ea = erase_active;
    next_exec = 1'b0;
    next_cmd = cmd_opcode;
    next_refused = refused;
    next_res_cnt = (res_cnt != 32'h0) ? res_cnt - 32'h1 : 32'h0;
    if (op_done) begin
      next_pa = 1'b0;
      next_ea = prog_active ? erase_active : 1'b0;
    end
    if (op_start_prog) begin
      next_pa = 1'b1;
    end
    if (op_start_erase) begin
      next_ea = 1'b1;
    end
    if (!cs_q && sck_q && !sck_d) begin
      next_shift = {shift[6:0], mosi_q};
      next_nbits = (nbits == 4'h7) ? 4'h0 : nbits + 4'h1;
      next_aligned = (nbits == 4'h7);
      if (nbits == 4'h7 && !have_op) begin
        next_opcode = {shift[6:0], mosi_q}; // R17
        next_have_op = 1'b1;
      end
    end
    if (cs_rise) begin
      next_nbits = 4'd0;
      next_have_op = 1'b0;
      next_aligned = 1'b0;
      if (have_op && aligned) begin // R4 R13 R17
        next_refused = !allowed || (needs_latch && !write_enable_latch);
        if (!allowed) begin
          next_refused = 1'b1; // R16
        end else if (opcode == OP_WREN) begin
          next_latch = 1'b1; // R11
        end else if (opcode == OP_WRDI) begin
          next_latch = 1'b0; // R12
        end else if (opcode == OP_RESUME) begin
          // Resume ignores the latch; program resumes before erase.
          if (program_suspended_flag) begin // R3 R5
            next_psusp = 1'b0; // R2
            next_res_cnt = RESUME_WAIT; // R1
          end else if (erase_suspended_flag) begin
            next_esusp = 1'b0; // R2
            next_res_cnt = RESUME_WAIT;
          end
        end else if (opcode == OP_SUSPEND) begin
          if (res_cnt == 32'h0) begin // R6
            if (prog_active && !program_suspended_flag) begin
              next_psusp = 1'b1; // R15
            end else if (erase_active && !erase_suspended_flag && !program_suspended_flag) begin
              next_esusp = 1'b1; // R15
            end
          end
        end else if (needs_latch && !write_enable_latch) begin
          next_refused = 1'b1; // R14
        end else begin
          next_exec = 1'b1;
          next_cmd = opcode;
          if (needs_latch) begin
            next_latch = 1'b0;
          end
        end
      end
    end
    // Ready while idle or while the running operation is suspended.
    next_ready = !((next_pa && !next_psusp) || (next_ea && !next_esusp && !next_pa)); // R15
  end

  // State registers.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cs_d <= 1'b1;
      sck_d <= 1'b0;
      shift <= 8'h00;
      nbits <= 4'h0;
      opcode <= 8'h00;
      have_op <= 1'b0;
      aligned <= 1'b0;
      write_enable_latch <= 1'b0;
      program_suspended_flag <= 1'b0;
      erase_suspended_flag <= 1'b0;
      ready_busy_flag <= 1'b1;
      prog_active <= 1'b0;
      erase_active <= 1'b0;
      cmd_exec <= 1'b0;
      cmd_opcode <= 8'h00;
      refused <= 1'b0;
      res_cnt <= 32'h0;
    end else begin
      cs_d <= cs_q;
      sck_d <= sck_q;
      shift <= next_shift;
      nbits <= next_nbits;
      opcode <= next_opcode;
      have_op <= next_have_op;
      aligned <= next_aligned;
      write_enable_latch <= next_latch;
      program_suspended_flag <= next_psusp;
      erase_suspended_flag <= next_esusp;
      ready_busy_flag <= next_ready;
      prog_active <= next_pa;
      erase_active <= next_ea;
      cmd_exec <= next_exec;
      cmd_opcode <= next_cmd;
      refused <= next_refused;
      res_cnt <= next_res_cnt;
    end
  end
endmodule

// file: logic/fsr_host_ctrl.sv
// SPI controller that sends one opcode byte per AXI4-Lite command write.
module fsr_host_ctrl
  import fsr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  fsr_link_if.host link,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  typedef enum logic [1:0] {FSR_IDLE, FSR_SHIFT, FSR_GAP} fsr_state_t;
  fsr_state_t st;
  fsr_state_t next_st;
  logic [7:0] dev_q;
  logic [7:0] dev_d;
  logic [7:0] tx;
  logic [7:0] next_tx;
  logic [3:0] bits;
  logic [3:0] next_bits;
  logic [3:0] half;
  logic [3:0] next_half;
  logic [3:0] keep;
  logic [3:0] next_keep;
  logic cs_o;
  logic next_cs;
  logic sck_o;
  logic next_sck;
  logic mosi_o;
  logic next_mosi;
  logic aw_ok;
  logic next_aw_ok;
  logic w_ok;
  logic next_w_ok;
  logic [7:0] aw_a;
  logic [7:0] next_aw_a;
  logic [31:0] w_d;
  logic [31:0] next_w_d;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [2:0] ist;
  logic [2:0] next_ist;
  logic [2:0] imask;
  logic [2:0] next_imask;
  logic next_irq;
  logic [2:0] ev;

  fsr_sync #(.WIDTH(8)) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin(link.dev_state),
    .init(8'h08),
    .level(dev_q)
  );
  assign link.cs_n = cs_o;
  assign link.sck = sck_o;
  assign link.mosi = mosi_o;
  // Events: frame done, refusal seen, device turned ready.
  assign ev = {dev_q[ST_BUSY] && !dev_d[ST_BUSY], dev_q[ST_REFUSED] && !dev_d[ST_REFUSED],
               st == FSR_GAP && half == 4'h0 && keep == 4'h0};

  // Frame engine and AXI slave.
  always_comb begin
    next_st = st;
    next_tx = tx;
    next_bits = bits;
    next_half = half;
    next_keep = keep;
    next_cs = cs_o;
    next_sck = sck_o;
    next_mosi = mosi_o;
    next_aw_ok = aw_ok;
    next_w_ok = w_ok;
    next_aw_a = aw_a;
    next_w_d = w_d;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_ist = ist | ev;
    next_imask = imask;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_ok = 1'b1;
      next_aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_ok = 1'b1;
      next_w_d = s_axi_wdata;
    end
    if (aw_ok && w_ok && !s_axi_bvalid) begin
      next_aw_ok = 1'b0;
      next_w_ok = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = AXI_OKAY;
      unique case (aw_a)
        REG_CMD: begin
          if (st == FSR_IDLE) begin
            // Whole byte plus optional bits[11:8] of extra clocks for an overlong, broken frame.
            next_st = FSR_SHIFT; // R4
            next_tx = w_d[7:0];
            next_keep = w_d[11:8];
            next_bits = 4'h8;
            next_half = 4'(SCK_HALF_CYCLES);
            next_cs = 1'b0;
            next_mosi = w_d[7];
          end else begin
            next_bresp = AXI_SLVERR;
          end
        end
        REG_IRQ_STAT: next_ist = (ist & ~w_d[2:0]) | ev;
        REG_IRQ_MASK: next_imask = w_d[2:0];
        REG_STATUS: next_bresp = AXI_OKAY;
        default: next_bresp = AXI_SLVERR;
      endcase
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = AXI_OKAY;
      unique case (s_axi_araddr)
        REG_CMD: next_rdata = {31'h0, st != FSR_IDLE};
        REG_STATUS: next_rdata = {24'h0, dev_q};
        REG_IRQ_STAT: next_rdata = {29'h0, ist};
        REG_IRQ_MASK: next_rdata = {29'h0, imask};
        default: begin
          next_rdata = 32'h0;
          next_rresp = AXI_SLVERR;
        end
      endcase
    end
    unique case (st)
      FSR_IDLE: begin
        next_cs = (next_st == FSR_SHIFT) ? 1'b0 : 1'b1;
      end
      FSR_SHIFT: begin
        next_half = half - 4'h1;
        if (half == 4'h0) begin
          next_half = 4'(SCK_HALF_CYCLES);
          next_sck = !sck_o;
          if (sck_o) begin
            // Falling edge moves the next bit out (mode 0).
            next_bits = bits - 4'h1;
            next_tx = {tx[6:0], 1'b0};
            next_mosi = tx[6];
            if (bits == 4'h1) begin
              next_st = FSR_GAP;
              next_bits = keep;
            end
          end
        end
      end
      FSR_GAP: begin
        next_half = half - 4'h1;
        if (half == 4'h0) begin
          next_half = 4'(SCK_HALF_CYCLES);
          if (keep != 4'h0) begin
            next_sck = !sck_o;
            if (sck_o) begin
              next_keep = keep - 4'h1;
            end
          end else begin
            next_cs = 1'b1;
            next_st = FSR_IDLE;
          end
        end
      end
      default: next_st = FSR_IDLE;
    endcase
    next_irq = |(next_ist & next_imask);
  end

  // Registers.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st <= FSR_IDLE;
      dev_d <= 8'h08;
      tx <= 8'h00;
      bits <= 4'h0;
      half <= 4'h0;
      keep <= 4'h0;
      cs_o <= 1'b1;
      sck_o <= 1'b0;
      mosi_o <= 1'b0;
      aw_ok <= 1'b0;
      w_ok <= 1'b0;
      aw_a <= 8'h00;
      w_d <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
      ist <= 3'h0;
      imask <= 3'h0;
      irq <= 1'b0;
    end else begin
      st <= next_st;
      dev_d <= dev_q;
      tx <= next_tx;
      bits <= next_bits;
      half <= next_half;
      keep <= next_keep;
      cs_o <= next_cs;
      sck_o <= next_sck;
      mosi_o <= next_mosi;
      aw_ok <= next_aw_ok;
      w_ok <= next_w_ok;
      aw_a <= next_aw_a;
      w_d <= next_w_d;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      ist <= next_ist;
      imask <= next_imask;
      irq <= next_irq;
    end
  end

  // Ready terms are registered-state derived.
  assign s_axi_awready = !aw_ok && !s_axi_bvalid;
  assign s_axi_wready = !w_ok && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
endmodule

// file: tb/fsr_link_asserts.sv
// Checker that watches the SPI link between the controller and the flash command logic.
module fsr_link_asserts (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic [7:0] dev_state
);
  logic sck_q;
  logic cs_q;
  logic [7:0] bit_cnt;
  logic [7:0] next_bit_cnt;

  // Counts rising serial clock edges in a frame, cleared once the link is idle.
  always_comb begin
    next_bit_cnt = bit_cnt;
    if (cs_n && cs_q) begin
      next_bit_cnt = 8'h00;
    end else if (sck && !sck_q) begin
      next_bit_cnt = bit_cnt + 8'h01;
    end
  end

  // Registers the edge detectors and the bit counter.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sck_q <= 1'b0;
      cs_q <= 1'b1;
      bit_cnt <= 8'h00;
    end else begin
      sck_q <= sck;
      cs_q <= cs_n;
      bit_cnt <= next_bit_cnt;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_sck_idle; cs_n |-> !sck; endproperty
  a_sck_idle: assert property (p_sck_idle)
    else $error("serial clock not low outside a frame");
  property p_cs_fall; $fell(cs_n) |-> !sck && !$past(sck); endproperty
  a_cs_fall: assert property (p_cs_fall)
    else $error("frame opened with serial clock high");
  property p_half; $rose(sck) |-> sck [*5] ##1 !sck; endproperty
  a_half: assert property (p_half)
    else $error("serial clock high phase has wrong length");
  property p_mosi; sck && $past(sck) |-> $stable(mosi); endproperty
  a_mosi: assert property (p_mosi)
    else $error("data line moved while serial clock high");
  property p_whole_op; $rose(cs_n) |-> bit_cnt >= 8'h08; endproperty
  a_whole_op: assert property (p_whole_op)
    else $error("frame closed before a whole opcode");
  property p_off_bound; $rose(cs_n) && bit_cnt[2:0] != 3'h0 |-> $stable(dev_state[2:0]) [*8];
  endproperty
  a_off_bound: assert property (p_off_bound)
    else $error("latch or suspend flags moved after a broken frame");
  property p_latch_cs; $changed(dev_state[0]) |-> cs_n; endproperty
  a_latch_cs: assert property (p_latch_cs)
    else $error("latch changed inside a frame");
  property p_flag_cs; $rose(dev_state[1]) || $rose(dev_state[2]) |-> cs_n; endproperty
  a_flag_cs: assert property (p_flag_cs)
    else $error("suspend flag set inside a frame");
  property p_resume; $rose(dev_state[4]) |-> dev_state[4] [*8]; endproperty
  a_resume: assert property (p_resume)
    else $error("resume window too short");
  property p_refuse; $rose(dev_state[5]) |-> $stable(dev_state[0]); endproperty
  a_refuse: assert property (p_refuse)
    else $error("refused command moved the latch");
endmodule

// file: tb/tb.sv
// Testbench that drives both ends of the link through the controller's register bus.
module tb
  import fsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} fsr_exp_t;
  localparam logic [7:0] BAD [19] = '{OP_WREN, OP_WRDI, OP_SUSPEND, OP_PROG, OP_PROG_ALT,
    OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K, OP_CHIP_ERASE, OP_CHIP_ERASE_ALT, OP_PROTECT,
    OP_UNPROTECT, OP_LOCKDOWN, OP_FREEZE, OP_OTP_PROG, OP_WRSR1, OP_WRSR2, OP_DEEP_PD,
    OP_DEEP_PD_EXIT};
  localparam logic [7:0] GOOD [9] = '{OP_READ_A, OP_READ_B, OP_READ_C, OP_READ_D, OP_RD_PROT,
    OP_RD_LOCK, OP_RD_OTP, OP_RD_STATUS, OP_RD_ID};
  logic core_clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, irq, op_start_prog, op_start_erase, op_done, cmd_exec;
  logic [7:0] awaddr, araddr, cmd_opcode;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp;
  fsr_exp_t exp_r[$];
  logic [1:0] exp_b[$];
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int seed = 85;

  fsr_link_if fsr_link_if_i ();
  fsr_flash_cmd #(.RESUME_WAIT(200)) fsr_flash_cmd_i (.core_clk(core_clk), .rst_n(rst_n),
    .link(fsr_link_if_i.dev), .op_start_prog(op_start_prog), .op_start_erase(op_start_erase),
    .op_done(op_done), .write_enable_latch(), .program_suspended_flag(),
    .erase_suspended_flag(), .ready_busy_flag(), .prog_active(), .erase_active(),
    .cmd_exec(cmd_exec), .cmd_opcode(cmd_opcode));
  fsr_host_ctrl fsr_host_ctrl_i (.core_clk(core_clk), .rst_n(rst_n), .link(fsr_link_if_i.host),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
  fsr_link_asserts fsr_link_asserts_i (.core_clk(core_clk), .rst_n(rst_n),
    .cs_n(fsr_link_if_i.cs_n), .sck(fsr_link_if_i.sck), .mosi(fsr_link_if_i.mosi),
    .dev_state(fsr_link_if_i.dev_state));

  // Clock source.
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Array engine stand-in: starts an operation for each executed program or erase command.
  always @(posedge core_clk) begin
    op_start_prog <= cmd_exec && (cmd_opcode == OP_PROG || cmd_opcode == OP_PROG_ALT);
    op_start_erase <= cmd_exec && (cmd_opcode inside {OP_ERASE_4K, OP_ERASE_32K,
      OP_ERASE_64K, OP_CHIP_ERASE, OP_CHIP_ERASE_ALT});
  end

  task automatic give_verdict();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic fail(input string s);
    n_errors++;
    $display("mismatch at %0t: %s", $time, s);
  endtask

  task automatic cmp_b(input logic [1:0] r);
    cmp_count++;
    if (bresp !== r) fail("write response");
  endtask

  task automatic cmp_r(input fsr_exp_t x);
    cmp_count++;
    if ((rdata & x.m) !== (x.d & x.m) || rresp !== x.r) fail("read data or response");
  endtask

  task automatic cmp_irq(input logic e);
    cmp_count++;
    if (irq !== e) fail("interrupt level");
  endtask

  // Watches the answers and compares each with the oldest note.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail("timeout");
      give_verdict();
    end
    if (bvalid && bready) cmp_b(exp_b.pop_front());
    if (rvalid && rready) cmp_r(exp_r.pop_front());
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    bit aw_done = 0;
    bit w_done = 0;
    exp_b.push_back(r);
    @(posedge core_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge core_clk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
      input logic [1:0] r, output logic [31:0] v);
    exp_r.push_back('{e, m, r});
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (rvalid !== 1'b1);
    v = rdata;
    rready <= 1'b0;
  endtask

  // Waits until the masked device state shows the value, then reads it once more as a check.
  task automatic chk(input logic [7:0] e, input logic [7:0] m);
    int n = 0;
    do begin
      axi_rd(REG_STATUS, 0, 0, AXI_OKAY, d);
      n++;
    end while ((d[7:0] & m) !== (e & m) && n < 120);
    axi_rd(REG_STATUS, {24'h0, e}, {24'h0, m}, AXI_OKAY, d);
  endtask

  // Sends one opcode frame with extra clocks, waits for it to finish, then checks the state.
  task automatic cmd(input logic [7:0] op, input logic [3:0] ex, input logic [7:0] e,
      input logic [7:0] m);
    int n = 0;
    axi_wr(REG_CMD, {20'h0, ex, op}, AXI_OKAY);
    do begin
      axi_rd(REG_CMD, 0, 0, AXI_OKAY, d);
      n++;
    end while (d[0] !== 1'b0 && n < 400);
    repeat (3) axi_rd(REG_STATUS, 0, 0, AXI_OKAY, d);
    chk(e, m);
  endtask

  function automatic logic [3:0] rnd_ex();
    logic [31:0] r = $random(seed);
    return {1'b0, r[2:0] | 3'h1};
  endfunction

  task automatic done_pulse();
    @(posedge core_clk) op_done <= 1'b1;
    @(posedge core_clk) op_done <= 1'b0;
  endtask

  // Main sequence.
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    op_done = 1'b0;
    rst_n = 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    axi_rd(REG_STATUS, 32'h08, 32'h2F, AXI_OKAY, d);
    axi_rd(8'h10, 0, 32'hFFFFFFFF, AXI_SLVERR, d);
    axi_wr(8'h14, 0, AXI_SLVERR);
    cmd(OP_WREN, 0, 8'h01, 8'h01);
    cmd(OP_WRDI, 0, 8'h00, 8'h01);
    cmd(OP_WREN, rnd_ex(), 8'h00, 8'h01);
    cmd(OP_WREN, 0, 8'h01, 8'h01);
    cmd(OP_WRDI, rnd_ex(), 8'h01, 8'h01);
    cmd(OP_WRDI, 0, 8'h00, 8'h01);
    cmd(OP_PROG, 0, 8'h08, 8'h09);
    cmd(OP_SUSPEND, 0, 8'h08, 8'h0E);
    cmd(OP_WREN, 0, 8'h01, 8'h01);
    cmd(OP_PROG, 0, 8'h00, 8'h09);
    cmd(OP_SUSPEND, 0, 8'h0A, 8'h0E);
    foreach (BAD[i]) cmd(BAD[i], 0, 8'h22, 8'h27);
    foreach (GOOD[i]) cmd(GOOD[i], 0, 8'h02, 8'h27);
    cmd(OP_RESUME, rnd_ex(), 8'h02, 8'h02);
    cmd(OP_RESUME, 0, 8'h10, 8'h10);
    cmd(OP_SUSPEND, 0, 8'h00, 8'h0A);
    chk(8'h00, 8'h16);
    done_pulse();
    chk(8'h08, 8'h0F);
    cmd(OP_WREN, 0, 8'h01, 8'h01);
    cmd(OP_ERASE_4K, 0, 8'h00, 8'h0F);
    cmd(OP_SUSPEND, 0, 8'h0C, 8'h0E);
    cmd(OP_WREN, 0, 8'h0D, 8'h2F);
    cmd(OP_PROG, 0, 8'h04, 8'h0F);
    cmd(OP_SUSPEND, 0, 8'h0E, 8'h0E);
    cmd(OP_RESUME, 0, 8'h04, 8'h06);
    chk(8'h04, 8'h16);
    done_pulse();
    chk(8'h0C, 8'h0E);
    cmd(OP_RESUME, 0, 8'h00, 8'h06);
    chk(8'h00, 8'h16);
    done_pulse();
    chk(8'h08, 8'h0F);
    axi_wr(REG_CMD, {24'h0, OP_RD_STATUS}, AXI_OKAY);
    axi_wr(REG_CMD, {24'h0, OP_RD_ID}, AXI_SLVERR);
    axi_rd(REG_IRQ_STAT, 32'h7, 32'h7, AXI_OKAY, d);
    axi_wr(REG_IRQ_MASK, 32'h7, AXI_OKAY);
    axi_rd(REG_IRQ_MASK, 32'h7, 32'h7, AXI_OKAY, d);
    cmp_irq(1'b1);
    axi_wr(REG_IRQ_MASK, 32'h0, AXI_OKAY);
    axi_rd(REG_IRQ_MASK, 32'h0, 32'h7, AXI_OKAY, d);
    cmp_irq(1'b0);
    axi_wr(REG_IRQ_STAT, 32'h7, AXI_OKAY);
    axi_rd(REG_IRQ_STAT, 32'h0, 32'h7, AXI_OKAY, d);
    cmp_irq(1'b0);
    give_verdict();
  end
endmodule
